// >>> hdl/cal_device.sv
// Behaviour
// - Four calibration modes in mode field
// - Writing calibration code starts calibration anytime
// - Result: subtract offset, then multiply gain
// - Calibration start raises not-ready and pin
// - Completion updates coefficient, clears not-ready, idles
// - Internal uses own reference; system uses pins
// - Host runs zero-scale before full-scale
// - Chop off zero-scale: four or three periods
// - Chop on: internal two, system settle
// - Internal full: settle, doubled above unity gain
// - System full-scale takes settle periods: four or three
// - Internal full only when rate word/16
// - Clock-divide bit doubles calibration time
// - Coefficients readable anytime, written when idle
// - Coefficients are 24-bit read/write registers
// - Host flags full-scale recalibration after gain change
// - Output period is 1024 times rate word
`timescale 1ns/100ps
`default_nettype none
module cal_device (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register link
  cal_if.dev bus,
  // Converter side
  input wire logic [cal_pkg::DW-1:0] raw_data,
  output logic [1:0] ref_sel,
  output logic cal_busy
);
  import cal_pkg::*;

  op_mode_t mode_r;
  logic third_r, chop_r, clkdiv_r, higain_r;
  logic [RATE_HI:0] rate_r;
  logic nrdy_r, busy_r;
  logic [DW-1:0] data_r, offs_r, fscl_r;
  logic [19:0] per_cnt_r;
  logic [4:0] cal_len_r, cal_cnt_r;
  logic [DW-1:0] rdata_r;
  logic rvalid_r;
  logic tick;
  logic wr_mode, is_cal_wr, cal_done;
  op_mode_t wmode;
  logic [19:0] per_len;
  logic [4:0] settle, len_nxt;
  logic signed [DW:0] diff;
  logic signed [49:0] prod;
  logic [DW-1:0] scaled;
  logic coef_wr_ok;

  assign wmode = op_mode_t'(bus.wdata[MODE_HI:MODE_LO]);
  assign wr_mode = bus.wr && bus.addr == ADDR_MODE;
  assign is_cal_wr = wr_mode && wmode[2];
  assign coef_wr_ok = mode_r == MD_IDLE || mode_r == MD_PDOWN;

  // Output period counter
  assign per_len = 20'(rate_r) * 20'(CLK_PER_STEP);
  assign tick = per_cnt_r >= per_len - 20'd1;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_r <= '0;
    end else if (wr_mode || tick) begin
      per_cnt_r <= '0;
    end else begin
      per_cnt_r <= per_cnt_r + 20'd1;
    end
  end

  // Calibration length from written settings
  always_comb begin
    settle = bus.wdata[BIT_THIRD_ORD] ? 5'(SETTLE3) : 5'(SETTLE4);
    case (wmode)
      MD_INT_ZERO: begin
        len_nxt = bus.wdata[BIT_CHOP] ? 5'(CHOP_ZERO) : settle;
      end
      MD_SYS_ZERO: begin
        len_nxt = settle;
      end
      MD_INT_FULL: begin
        len_nxt = bus.wdata[BIT_HIGAIN] ? 5'(settle << 1) : settle;
      end
      MD_SYS_FULL: begin
        len_nxt = settle;
      end
      default: begin
        len_nxt = settle;
      end
    endcase
    if (bus.wdata[BIT_CLKDIV]) begin
      len_nxt = 5'(len_nxt << 1);
    end
  end

  assign cal_done = busy_r && tick && (cal_cnt_r + 5'd1 >= cal_len_r);

  // Mode register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= op_mode_t'(MODE_RST[MODE_HI:MODE_LO]);
      third_r <= MODE_RST[BIT_THIRD_ORD];
      chop_r <= MODE_RST[BIT_CHOP];
      clkdiv_r <= MODE_RST[BIT_CLKDIV];
      higain_r <= MODE_RST[BIT_HIGAIN];
      rate_r <= MODE_RST[RATE_HI:0];
    end else if (wr_mode) begin
      mode_r <= wmode;
      third_r <= bus.wdata[BIT_THIRD_ORD];
      chop_r <= bus.wdata[BIT_CHOP];
      clkdiv_r <= bus.wdata[BIT_CLKDIV];
      higain_r <= bus.wdata[BIT_HIGAIN];
      rate_r <= bus.wdata[RATE_HI:0];
    end else if (cal_done || (mode_r == MD_SINGLE && tick)) begin
      mode_r <= MD_IDLE;
    end
  end

  // Calibration sequencing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      cal_cnt_r <= '0;
      cal_len_r <= '0;
    end else if (wr_mode) begin
      busy_r <= is_cal_wr;
      cal_cnt_r <= '0;
      cal_len_r <= len_nxt;
    end else if (cal_done) begin
      busy_r <= 1'b0;
    end else if (busy_r && tick) begin
      cal_cnt_r <= cal_cnt_r + 5'd1;
    end
  end

  // Not-ready flag: start wins over completion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nrdy_r <= 1'b1;
    end else if (is_cal_wr) begin
      nrdy_r <= 1'b1;
    end else if (cal_done) begin
      nrdy_r <= 1'b0;
    end else if (!busy_r && tick && (mode_r == MD_CONT || mode_r == MD_SINGLE)) begin
      nrdy_r <= 1'b0;
    end else if (bus.rd && bus.addr == ADDR_DATA) begin
      nrdy_r <= 1'b1;
    end
  end

  // Result scaling
  assign diff = $signed({1'b0, raw_data}) - $signed({1'b0, offs_r});
  assign prod = 50'(diff) * $signed({26'd0, fscl_r});
  assign scaled = 24'(prod >>> GAIN_SHIFT) + MID_CODE;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= '0;
    end else if (!busy_r && tick && (mode_r == MD_CONT || mode_r == MD_SINGLE)) begin
      data_r <= scaled;
    end
  end

  // Coefficient registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offs_r <= OFFS_RST;
    end else if (cal_done && (mode_r == MD_INT_ZERO || mode_r == MD_SYS_ZERO)) begin
      offs_r <= raw_data;
    end else if (bus.wr && bus.addr == ADDR_OFFS && coef_wr_ok) begin
      offs_r <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fscl_r <= FSCL_RST;
    end else if (cal_done && (mode_r == MD_INT_FULL || mode_r == MD_SYS_FULL)) begin
      fscl_r <= raw_data;
    end else if (bus.wr && bus.addr == ADDR_FSCL && coef_wr_ok) begin
      fscl_r <= bus.wdata;
    end
  end

  // Register read, answered one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= bus.rd;
      if (bus.rd) begin
        case (bus.addr)
          ADDR_MODE: begin
            rdata_r <= {mode_r, third_r, chop_r, clkdiv_r, higain_r, 7'd0, rate_r};
          end
          ADDR_STAT: begin
            rdata_r <= {16'd0, nrdy_r, busy_r, 6'd0};
          end
          ADDR_DATA: begin
            rdata_r <= data_r;
          end
          ADDR_OFFS: begin
            rdata_r <= offs_r;
          end
          ADDR_FSCL: begin
            rdata_r <= fscl_r;
          end
          default: begin
            rdata_r <= '0;
          end
        endcase
      end
    end
  end

  // Reference routing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_sel <= REF_PINS;
    end else if (busy_r && mode_r == MD_INT_ZERO) begin
      ref_sel <= REF_ZERO;
    end else if (busy_r && mode_r == MD_INT_FULL) begin
      ref_sel <= REF_FULL;
    end else begin
      ref_sel <= REF_PINS;
    end
  end

  assign bus.rdata = rdata_r;
  assign bus.rvalid = rvalid_r;
  assign bus.rdy_n_o = nrdy_r;
  assign bus.rdy_n_oe = !bus.cs_n;
  assign cal_busy = busy_r;
endmodule : cal_device
`default_nettype wire

// >>> hdl/cal_pkg.sv
package cal_pkg;
  // Register addresses
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_STAT = 3'h1;
  localparam logic [2:0] ADDR_DATA = 3'h2;
  localparam logic [2:0] ADDR_OFFS = 3'h3;
  localparam logic [2:0] ADDR_FSCL = 3'h4;
  localparam int AW = 3;
  localparam int DW = 24;
  // Mode register fields
  localparam int MODE_HI = 23;
  localparam int MODE_LO = 21;
  localparam int BIT_THIRD_ORD = 20;
  localparam int BIT_CHOP = 19;
  localparam int BIT_CLKDIV = 18;
  localparam int BIT_HIGAIN = 17;
  localparam int RATE_HI = 9;
  // Status register fields
  localparam int BIT_NRDY = 7;
  localparam int BIT_BUSY = 6;
  // Operating modes
  typedef enum logic [2:0] {
    MD_CONT = 3'b000,
    MD_SINGLE = 3'b001,
    MD_IDLE = 3'b010,
    MD_PDOWN = 3'b011,
    MD_INT_ZERO = 3'b100,
    MD_INT_FULL = 3'b101,
    MD_SYS_ZERO = 3'b110,
    MD_SYS_FULL = 3'b111
  } op_mode_t;
  // Reference routing
  localparam logic [1:0] REF_PINS = 2'h0;
  localparam logic [1:0] REF_ZERO = 2'h1;
  localparam logic [1:0] REF_FULL = 2'h2;
  // Reset values
  localparam logic [23:0] MODE_RST = 24'h00_0060;
  localparam logic [23:0] OFFS_RST = 24'h80_0000;
  localparam logic [23:0] FSCL_RST = 24'h80_0000;
  localparam logic [23:0] MID_CODE = 24'h80_0000;
  // Timing: one output period is this many clocks per filter-rate step
  localparam int CLK_PER_STEP = 1024;
  localparam int GAIN_SHIFT = 23;
  localparam int SETTLE4 = 4;
  localparam int SETTLE3 = 3;
  localparam int CHOP_ZERO = 2;
  localparam int RATE_ALIGN = 16;
endpackage : cal_pkg

// >>> hdl/cal_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cal_if;
  import cal_pkg::*;
  logic wr;
  logic rd;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic rvalid;
  logic cs_n;
  logic rdy_n_o;
  logic rdy_n_oe;
  logic rdy_n;
  // Pin level: pulled high when the device does not drive
  assign rdy_n = rdy_n_oe ? rdy_n_o : 1'b1;
  modport dev (
    input wr, rd, addr, wdata, cs_n,
    output rdata, rvalid, rdy_n_o, rdy_n_oe
  );
  modport hst (
    output wr, rd, addr, wdata, cs_n,
    input rdata, rvalid, rdy_n
  );
endinterface : cal_if
`default_nettype wire

// >>> hdl/cal_host.sv
`timescale 1ns/100ps
`default_nettype none
module cal_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register link
  cal_if.hst bus,
  // User command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [cal_pkg::AW-1:0] cmd_addr,
  input wire logic [cal_pkg::DW-1:0] cmd_wdata,
  output logic cmd_err,
  output logic rsp_valid,
  output logic [cal_pkg::DW-1:0] rsp_data,
  // Status
  input wire logic low_supply,
  output logic recal_needed
);
  import cal_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_READ = 2'b01
  } hstate_t;

  hstate_t st_r;
  op_mode_t shadow_r;
  logic zero_done_r, recal_r, gain_r;
  logic wr_r, rd_r, err_r, rsp_v_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r, rsp_r;
  logic take, refuse, mode_wr, coef_wr;
  op_mode_t m;
  logic [DW-1:0] wfix;

  assign cmd_ready = st_r == H_IDLE;
  assign take = cmd_valid && cmd_ready;
  assign m = op_mode_t'(cmd_wdata[MODE_HI:MODE_LO]);
  assign mode_wr = cmd_write && cmd_addr == ADDR_MODE;
  assign coef_wr = cmd_write && (cmd_addr == ADDR_OFFS || cmd_addr == ADDR_FSCL);

  always_comb begin
    refuse = 1'b0;
    wfix = cmd_wdata;
    if (mode_wr && (m == MD_INT_FULL || m == MD_SYS_FULL) && !zero_done_r) begin
      refuse = 1'b1;
    end
    if (mode_wr && m == MD_INT_FULL && (cmd_wdata[3:0] & 4'(RATE_ALIGN - 1)) != 4'h0) begin
      refuse = 1'b1;
    end
    if (coef_wr && !(shadow_r == MD_IDLE || shadow_r == MD_PDOWN)) begin
      refuse = 1'b1;
    end
    if (mode_wr && m == MD_INT_FULL && low_supply) begin
      wfix[BIT_CLKDIV] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= H_IDLE;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      err_r <= 1'b0;
      rsp_v_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      rsp_r <= '0;
    end else begin
      wr_r <= take && cmd_write && !refuse;
      rd_r <= take && !cmd_write;
      err_r <= take && cmd_write && refuse;
      rsp_v_r <= 1'b0;
      if (take) begin
        addr_r <= cmd_addr;
        wdata_r <= wfix;
      end
      case (st_r)
        H_IDLE: begin
          if (take && !cmd_write) begin
            st_r <= H_READ;
          end
        end
        H_READ: begin
          if (bus.rvalid) begin
            rsp_r <= bus.rdata;
            rsp_v_r <= 1'b1;
            st_r <= H_IDLE;
          end
        end
        default: begin
          st_r <= H_IDLE;
        end
      endcase
    end
  end

  // Device mode tracking and calibration bookkeeping
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_r <= op_mode_t'(MODE_RST[MODE_HI:MODE_LO]);
      zero_done_r <= 1'b0;
      recal_r <= 1'b0;
      gain_r <= MODE_RST[BIT_HIGAIN];
    end else if (take && mode_wr && !refuse) begin
      shadow_r <= m;
      gain_r <= cmd_wdata[BIT_HIGAIN];
      if (m == MD_INT_ZERO || m == MD_SYS_ZERO) begin
        zero_done_r <= 1'b1;
      end else if (cmd_wdata[BIT_HIGAIN] != gain_r) begin
        zero_done_r <= 1'b0;
      end
      if (m == MD_INT_FULL || m == MD_SYS_FULL) begin
        recal_r <= 1'b0;
      end else if (cmd_wdata[BIT_HIGAIN] != gain_r) begin
        recal_r <= 1'b1;
      end
    end else if (shadow_r[2] && !wr_r && !bus.rdy_n) begin
      shadow_r <= MD_IDLE;
    end
  end

  assign bus.wr = wr_r;
  assign bus.rd = rd_r;
  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.cs_n = 1'b0;
  assign cmd_err = err_r;
  assign rsp_valid = rsp_v_r;
  assign rsp_data = rsp_r;
  assign recal_needed = recal_r;
endmodule : cal_host
`default_nettype wire

// >>> verification/cal_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module cal_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link signals
  input wire logic wr,
  input wire logic rd,
  input wire logic [cal_pkg::AW-1:0] addr,
  input wire logic [cal_pkg::DW-1:0] wdata,
  input wire logic [cal_pkg::DW-1:0] rdata,
  input wire logic rvalid,
  input wire logic cs_n,
  input wire logic rdy_n_o,
  input wire logic rdy_n_oe,
  input wire logic rdy_n
);
  import cal_pkg::*;
  logic [23:0] mode_r;
  logic cal_r;
  logic zero_r;
  logic mw;
  int cnt_r;
  int per;
  int exp_len;
  assign mw = wr && addr == ADDR_MODE;
  // Shadow of the mode word and cycles since its last write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) mode_r <= MODE_RST;
    else if (mw) mode_r <= wdata;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_r <= 0;
    else if (mw) cnt_r <= 0;
    else cnt_r <= cnt_r + 1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cal_r <= 1'b0;
    else if (mw) cal_r <= wdata[MODE_HI];
    else if (!rdy_n_o) cal_r <= 1'b0;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) zero_r <= 1'b0;
    else if (mw && wdata[22:21] == 2'b00 && wdata[MODE_HI]) zero_r <= 1'b1;
    else if (mw && wdata[BIT_HIGAIN] != mode_r[BIT_HIGAIN]) zero_r <= 1'b0;
  end
  // Expected calibration length in clocks
  always_comb begin
    per = mode_r[BIT_THIRD_ORD] ? SETTLE3 : SETTLE4;
    if (mode_r[23:21] == MD_INT_ZERO && mode_r[BIT_CHOP]) per = CHOP_ZERO;
    if (mode_r[23:21] == MD_INT_FULL && mode_r[BIT_HIGAIN]) per = 2 * per;
    exp_len = per * (mode_r[BIT_CLKDIV] ? 2 : 1) * CLK_PER_STEP * int'(mode_r[RATE_HI:0]);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rd_answer; rd |=> rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rvalid_cause; rvalid |-> $past(rd); endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray answer");
  property p_cal_start; mw && wdata[MODE_HI] |=> rdy_n_o; endproperty
  a_cal_start: assert property (p_cal_start) else $error("ready not raised");
  property p_cal_hold; cal_r && cnt_r + 4 < exp_len |-> rdy_n_o; endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("calibration ended early");
  property p_cal_len;
    $fell(rdy_n_o) && cal_r |-> cnt_r + 4 >= exp_len && cnt_r <= exp_len + 4;
  endproperty
  a_cal_len: assert property (p_cal_len)
    else $error("bad length");
  property p_pin_drive; !cs_n |-> rdy_n_oe && rdy_n == rdy_n_o; endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin not driven");
  property p_full_align; mw && wdata[23:21] == MD_INT_FULL |-> wdata[3:0] == 4'h0; endproperty
  a_full_align: assert property (p_full_align) else $error("unaligned rate word");
  property p_zero_first; mw && wdata[MODE_HI] && wdata[21] && wdata[22] == wdata[21] |-> zero_r;
  endproperty
  a_zero_first: assert property (p_zero_first) else $error("full before zero");
endmodule : cal_assertions
`default_nettype wire

// >>> verification/adc_calibration_sequencer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module adc_calibration_sequencer_bench;
  import cal_pkg::*;
  typedef struct {logic [23:0] mode; int len; logic [1:0] rsel; logic [2:0] coef;} row_t;
  row_t rows [5] = '{'{24'h80_0001, 4096, 2'h1, ADDR_OFFS}, '{24'h88_0001, 2048, 2'h1, ADDR_OFFS},
    '{24'hd0_0001, 3072, 2'h0, ADDR_OFFS}, '{24'he4_0001, 8192, 2'h0, ADDR_FSCL},
    '{24'hb0_0010, 49152, 2'h2, ADDR_FSCL}};
  logic clk, rst_n, cmd_valid, cmd_ready, cmd_write, cmd_err, rsp_valid, low_supply;
  logic recal_needed, cal_busy, err;
  logic [2:0] cmd_addr;
  logic [23:0] cmd_wdata, rsp_data, raw_data, d;
  logic [1:0] ref_sel;
  int miscompares, num_checks, n;
  cal_if cal_if_i ();
  cal_device cal_device_i (.clk(clk), .rst_n(rst_n), .bus(cal_if_i), .raw_data(raw_data),
    .ref_sel(ref_sel), .cal_busy(cal_busy));
  cal_host cal_host_i (.clk(clk), .rst_n(rst_n), .bus(cal_if_i), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_err(cmd_err), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .low_supply(low_supply),
    .recal_needed(recal_needed));
  cal_assertions cal_assertions_i (.clk(clk), .rst_n(rst_n), .wr(cal_if_i.wr), .rd(cal_if_i.rd),
    .addr(cal_if_i.addr), .wdata(cal_if_i.wdata), .rdata(cal_if_i.rdata),
    .rvalid(cal_if_i.rvalid), .cs_n(cal_if_i.cs_n), .rdy_n_o(cal_if_i.rdy_n_o),
    .rdy_n_oe(cal_if_i.rdy_n_oe), .rdy_n(cal_if_i.rdy_n));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // One host command; collects refusal and read answer
  task automatic cmd(input logic w, input logic [2:0] a, input logic [23:0] wd);
    @(posedge clk);
    #1;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = wd;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    err = 1'b0;
    d = 'x;
    repeat (5) begin
      if (cmd_err === 1'b1) err = 1'b1;
      if (rsp_valid === 1'b1) d = rsp_data;
      @(posedge clk);
      #1;
    end
  endtask : cmd
  task automatic wait_rdy;
    n = 0;
    while (cal_if_i.rdy_n !== 1'b0 && n < 60000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_rdy
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 3'h0;
    cmd_wdata = 24'h0;
    raw_data = 24'h0;
    low_supply = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    cmd(1'b0, ADDR_MODE, 24'h0);
    chk(d, MODE_RST);
    cmd(1'b0, ADDR_OFFS, 24'h0);
    chk(d, OFFS_RST);
    cmd(1'b0, ADDR_FSCL, 24'h0);
    chk(d, FSCL_RST);
    cmd(1'b1, ADDR_OFFS, 24'h12_3456);
    chk(24'(err), 24'h1);
    foreach (rows[i]) begin
      raw_data = 24'h10_0000 + 24'(i);
      cmd(1'b1, ADDR_MODE, rows[i].mode);
      chk(24'({err, cal_if_i.rdy_n, cal_busy}), 24'h3);
      chk(24'(ref_sel), 24'(rows[i].rsel));
      wait_rdy();
      chk(24'(n + 12 > rows[i].len), 24'h1);
      chk(24'(n < rows[i].len + 2), 24'h1);
      // Routing is registered one clock behind the busy flag
      @(posedge clk);
      #1;
      chk(24'({cal_busy, ref_sel}), 24'h0);
      cmd(1'b0, rows[i].coef, 24'h0);
      chk(d, raw_data);
      cmd(1'b0, ADDR_MODE, 24'h0);
      chk(24'(d[23:21]), 24'(MD_IDLE));
      cmd(1'b0, ADDR_STAT, 24'h0);
      chk(24'(d[BIT_NRDY]), 24'h0);
    end
    cmd(1'b1, ADDR_OFFS, 24'h00_0100);
    chk(24'(err), 24'h0);
    cmd(1'b1, ADDR_FSCL, MID_CODE);
    cmd(1'b0, ADDR_OFFS, 24'h0);
    chk(d, 24'h00_0100);
    raw_data = 24'h00_0300;
    // A data read raises not-ready so the first conversion shows on the pin
    cmd(1'b0, ADDR_DATA, 24'h0);
    chk(24'(cal_if_i.rdy_n), 24'h1);
    cmd(1'b1, ADDR_MODE, 24'h00_0001);
    wait_rdy();
    chk(24'(n + 12 > CLK_PER_STEP && n < CLK_PER_STEP + 2), 24'h1);
    cmd(1'b0, ADDR_DATA, 24'h0);
    chk(d, 24'h80_0200);
    cmd(1'b1, ADDR_MODE, 24'h40_0001);
    cmd(1'b1, ADDR_MODE, 24'ha0_0001);
    chk(24'({err, cal_busy}), 24'h2);
    raw_data = 24'h55_5555;
    cmd(1'b1, ADDR_MODE, 24'h80_0001);
    repeat (100) @(posedge clk);
    cmd(1'b1, ADDR_MODE, 24'h40_0001);
    chk(24'(cal_busy), 24'h0);
    cmd(1'b0, ADDR_OFFS, 24'h0);
    chk(d, 24'h00_0100);
    low_supply = 1'b1;
    cmd(1'b1, ADDR_MODE, 24'ha0_0010);
    chk(24'({cal_if_i.wdata[BIT_CLKDIV], cal_busy}), 24'h3);
    low_supply = 1'b0;
    cmd(1'b1, ADDR_MODE, 24'h40_0001);
    chk(24'(cal_busy), 24'h0);
    cmd(1'b1, ADDR_MODE, 24'h42_0001);
    chk(24'(recal_needed), 24'h1);
    cmd(1'b1, ADDR_MODE, 24'he0_0001);
    chk(24'(err), 24'h1);
    summarize();
  end
endmodule : adc_calibration_sequencer_bench
`default_nettype wire
